// ==== src/misc_op_map.svh ====
// Opcode values, reset values and widths for the misc control decoder
`ifndef MISC_OP_MAP_SVH
`define MISC_OP_MAP_SVH

`define OPC_WIDTH 10
`define OPC_WATCHDOG_HALT 10'h29c
`define OPC_IRQ_PERMIT 10'h005
`define OPC_POWERDOWN_ARM 10'h05b
`define OPC_PORT0_READ 10'h260

`define PORT_WIDTH_DEF 4
`define RST_FLAG 1'b0
`define SET_FLAG 1'b1
`define RST_ACC 4'h0

`endif

// ==== src/misc_op_pkg.sv ====
// Types shared by the misc control decoder and its bench
package misc_op_pkg;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_WATCHDOG_HALT,
        OP_IRQ_PERMIT,
        OP_POWERDOWN_ARM,
        OP_PORT0_READ
    } decoded_op_e;

    typedef enum logic [1:0] {
        WDT_RUNNING,
        WDT_HALT_ARMED,
        WDT_HALTED
    } watchdog_state_e;

endpackage

// ==== src/sync_2ff.sv ====
// Two-stage synchroniser for a group of pin inputs
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gBit
            logic meta_q;
            logic stable_q;
            // First stage feeds only the second
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    meta_q <= 1'b0;
                    stable_q <= 1'b0;
                end else begin
                    meta_q <= asyncIn[i];
                    stable_q <= meta_q;
                end
            end
            assign syncOut[i] = stable_q;
        end
    endgenerate

endmodule // sync_2ff

// ==== src/misc_control_opcode_decode.sv ====
// Decode and execute of the watchdog-halt, irq-permit, power-down-arm and port-0 read ops
`include "misc_op_map.svh"

module misc_control_opcode_decode #(
    parameter int PORT_WIDTH = `PORT_WIDTH_DEF
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic execStrobe,
    input wire logic [`OPC_WIDTH-1:0] instrWord,
    input wire logic watchdogConfirmOp,
    input wire logic powerdownOp,
    input wire logic deepPowerdownOp,
    input wire logic irqPermitClear,
    input wire logic [PORT_WIDTH-1:0] inputPortZero,
    output logic opRecognised,
    output misc_op_pkg::decoded_op_e lastOp,
    output logic skipNext,
    output logic carryWrite,
    output logic watchdogHaltArmed,
    output logic watchdogHalted,
    output logic irqPermitFlag,
    output logic irqAcceptEnable,
    output logic powerdownArmed,
    output logic powerdownReq,
    output logic deepPowerdownReq,
    output logic accLoad,
    output logic [PORT_WIDTH-1:0] accData
);
    import misc_op_pkg::*;

    generate
        if (PORT_WIDTH < 1 || PORT_WIDTH > 16) begin : gBadWidth
            $error("PORT_WIDTH must be 1 to 16");
        end
    endgenerate

    // Port pins are asynchronous to the core clock
    logic [PORT_WIDTH-1:0] portSync;

    sync_2ff #(
        .WIDTH(PORT_WIDTH)
    ) uPortSync (
        .sys_clk(sys_clk),
        .srst(srst),
        .asyncIn(inputPortZero),
        .syncOut(portSync)
    );

    // Opcode decode, qualified by the execute strobe
    wire hitWatchdogHalt;
    wire hitIrqPermit;
    wire hitPowerdownArm;
    wire hitPort0Read;
    wire anyHit;
    wire powerdownUse;
    wire powerdownGo;
    logic powerdownArmed_q;

    assign hitWatchdogHalt = execStrobe && (instrWord == `OPC_WATCHDOG_HALT);
    assign hitIrqPermit = execStrobe && (instrWord == `OPC_IRQ_PERMIT);
    assign hitPowerdownArm = execStrobe && (instrWord == `OPC_POWERDOWN_ARM);
    assign hitPort0Read = execStrobe && (instrWord == `OPC_PORT0_READ);
    assign anyHit = hitWatchdogHalt || hitIrqPermit || hitPowerdownArm || hitPort0Read;

    assign powerdownUse = execStrobe && (powerdownOp || deepPowerdownOp);
    assign powerdownGo = powerdownUse && powerdownArmed_q;

    decoded_op_e opSel;
    assign opSel = hitWatchdogHalt ? OP_WATCHDOG_HALT :
                   hitIrqPermit ? OP_IRQ_PERMIT :
                   hitPowerdownArm ? OP_POWERDOWN_ARM :
                   hitPort0Read ? OP_PORT0_READ : OP_NONE;

    // Recognition pulse and last decoded op
    logic opRecognised_q;
    decoded_op_e lastOp_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            opRecognised_q <= `RST_FLAG;
            lastOp_q <= OP_NONE;
        end else begin
            opRecognised_q <= anyHit;
            if (anyHit) begin
                lastOp_q <= opSel;
            end
        end
    end

    // Watchdog halt sequencing
    watchdog_state_e wdtState_q;
    watchdog_state_e wdtState_d;

    always_comb begin
        wdtState_d = wdtState_q;
        case (wdtState_q)
            WDT_RUNNING: begin
                if (hitWatchdogHalt) begin
                    wdtState_d = WDT_HALT_ARMED;
                end
            end
            WDT_HALT_ARMED: begin
                // Confirm in the arming cycle itself does not count
                if (execStrobe && watchdogConfirmOp && !hitWatchdogHalt) begin
                    wdtState_d = WDT_HALTED;
                end
            end
            WDT_HALTED: begin
                // Only reset restarts the watchdog
                wdtState_d = WDT_HALTED;
            end
            default: begin
                wdtState_d = WDT_RUNNING;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wdtState_q <= WDT_RUNNING;
        end else begin
            wdtState_q <= wdtState_d;
        end
    end

    // Interrupt permit flag and its delayed acceptance
    logic irqPermit_q;
    logic irqPermit_d;
    logic irqAccept_q;

    // set wins over an external clear
    assign irqPermit_d = hitIrqPermit ? `SET_FLAG :
                         irqPermitClear ? `RST_FLAG : irqPermit_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irqPermit_q <= `RST_FLAG;
        end else begin
            irqPermit_q <= irqPermit_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irqAccept_q <= `RST_FLAG;
        end else if (!irqPermit_d) begin
            // A clear drops acceptance at once, no grace cycle
            irqAccept_q <= `RST_FLAG;
        end else if (execStrobe) begin
            irqAccept_q <= irqPermit_q;
        end
    end

    // Power-down arming and gated requests
    logic powerdownReq_q;
    logic deepPowerdownReq_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            powerdownArmed_q <= `RST_FLAG;
        end else if (hitPowerdownArm) begin
            powerdownArmed_q <= `SET_FLAG;
        end else if (powerdownUse) begin
            powerdownArmed_q <= `RST_FLAG;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            powerdownReq_q <= `RST_FLAG;
            deepPowerdownReq_q <= `RST_FLAG;
        end else begin
            powerdownReq_q <= powerdownGo && powerdownOp && !deepPowerdownOp;
            deepPowerdownReq_q <= powerdownGo && deepPowerdownOp;
        end
    end

    // Accumulator load from port 0
    logic accLoad_q;
    logic [PORT_WIDTH-1:0] accData_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            accLoad_q <= `RST_FLAG;
            accData_q <= PORT_WIDTH'(`RST_ACC);
        end else begin
            accLoad_q <= hitPort0Read;
            if (hitPort0Read) begin
                accData_q <= portSync;
            end
        end
    end

    // none of these ops skip or write carry
    assign skipNext = `RST_FLAG;
    assign carryWrite = `RST_FLAG;

    assign opRecognised = opRecognised_q;
    assign lastOp = lastOp_q;
    assign watchdogHaltArmed = (wdtState_q == WDT_HALT_ARMED);
    assign watchdogHalted = (wdtState_q == WDT_HALTED);
    assign irqPermitFlag = irqPermit_q;
    assign irqAcceptEnable = irqAccept_q;
    assign powerdownArmed = powerdownArmed_q;
    assign powerdownReq = powerdownReq_q;
    assign deepPowerdownReq = deepPowerdownReq_q;
    assign accLoad = accLoad_q;
    assign accData = accData_q;

endmodule // misc_control_opcode_decode

// ==== bench/misc_control_checker.sv ====
// Concurrent checks on the misc control decoder ports
`include "misc_op_map.svh"
module misc_control_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic execStrobe,
    input wire logic [`OPC_WIDTH-1:0] instrWord,
    input wire logic watchdogConfirmOp,
    input wire logic powerdownOp,
    input wire logic deepPowerdownOp,
    input wire logic opRecognised,
    input misc_op_pkg::decoded_op_e lastOp,
    input wire logic skipNext,
    input wire logic carryWrite,
    input wire logic watchdogHaltArmed,
    input wire logic watchdogHalted,
    input wire logic irqPermitFlag,
    input wire logic irqAcceptEnable,
    input wire logic powerdownArmed,
    input wire logic powerdownReq,
    input wire logic deepPowerdownReq,
    input wire logic accLoad
);
    timeunit 1ns;
    timeprecision 1ps;
    import misc_op_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire logic pdAny = powerdownOp | deepPowerdownOp;
    wire logic notArm = instrWord != `OPC_POWERDOWN_ARM;

    a_halt_word_arms: assert property (execStrobe && instrWord == `OPC_WATCHDOG_HALT
        && !watchdogHalted |=> watchdogHaltArmed && opRecognised && lastOp == OP_WATCHDOG_HALT)
        else $error("halt word did not arm");
    a_no_skip_carry: assert property (!skipNext && !carryWrite)
        else $error("skip or carry touched");
    a_halt_after_arm: assert property ($rose(watchdogHalted) |-> $past(watchdogHaltArmed)
        && $past(execStrobe) && $past(watchdogConfirmOp)) else $error("halt without arming");
    a_permit_sets: assert property (execStrobe && instrWord == `OPC_IRQ_PERMIT
        |=> irqPermitFlag) else $error("permit flag not set");
    a_accept_delayed: assert property (execStrobe && instrWord == `OPC_IRQ_PERMIT
        && !irqPermitFlag |=> !irqAcceptEnable) else $error("accept came too early");
    a_pd_arms: assert property (execStrobe && instrWord == `OPC_POWERDOWN_ARM
        |=> powerdownArmed) else $error("power-down not armed");
    a_port_load: assert property (execStrobe && instrWord == `OPC_PORT0_READ
        |=> accLoad && lastOp == OP_PORT0_READ
        ##1 (!accLoad || $past(execStrobe) && $past(instrWord) == `OPC_PORT0_READ))
        else $error("port read load wrong");
    a_pd_unarmed: assert property (execStrobe && pdAny && !powerdownArmed && notArm
        |=> !powerdownReq && !deepPowerdownReq) else $error("unarmed power-down acted");
    a_pd_disarms: assert property (execStrobe && pdAny && powerdownArmed && notArm
        |=> !powerdownArmed && (powerdownReq || deepPowerdownReq) ##1 !powerdownReq)
        else $error("power-down use did not disarm");
endmodule // misc_control_checker

bind misc_control_opcode_decode misc_control_checker u_checker (.*);

// ==== bench/misc_control_opcode_decode_tb.sv ====
// Directed testbench for the misc control decoder
`include "misc_op_map.svh"
module misc_control_opcode_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import misc_op_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic execStrobe = 1'b0;
    logic [9:0] instrWord = 10'h000;
    logic watchdogConfirmOp = 1'b0;
    logic powerdownOp = 1'b0;
    logic deepPowerdownOp = 1'b0;
    logic irqPermitClear = 1'b0;
    logic [3:0] inputPortZero = 4'h5;
    logic opRecognised, skipNext, carryWrite, watchdogHaltArmed, watchdogHalted;
    logic irqPermitFlag, irqAcceptEnable, powerdownArmed, powerdownReq, deepPowerdownReq;
    logic accLoad;
    logic [3:0] accData;
    decoded_op_e lastOp;
    int errCount = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 sys_clk = ~sys_clk;
    misc_control_opcode_decode dut (.*);

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One machine cycle; outputs are settled when this returns
    task automatic exec(input logic [9:0] w, input logic c, input logic p, input logic d);
        @(negedge sys_clk);
        execStrobe = 1'b1;
        instrWord = w;
        watchdogConfirmOp = c;
        powerdownOp = p;
        deepPowerdownOp = d;
        @(negedge sys_clk);
        execStrobe = 1'b0;
        instrWord = 10'h000;
        watchdogConfirmOp = 1'b0;
        powerdownOp = 1'b0;
        deepPowerdownOp = 1'b0;
    endtask

    task automatic t_port();
        // Pins settle through the synchroniser first
        repeat (3) @(negedge sys_clk);
        exec(`OPC_PORT0_READ, 0, 0, 0);
        chk("accLoad", 1, accLoad);
        chk("accData", 4'h5, accData);
        chk("lastOp", OP_PORT0_READ, lastOp);
        chk("skipCarry", 0, {skipNext, carryWrite});
        inputPortZero = 4'ha;
        repeat (3) @(negedge sys_clk);
        chk("accLoadOff", 0, accLoad);
        exec(`OPC_PORT0_READ, 0, 0, 0);
        chk("accData", 4'ha, accData);
        $display("port read test done");
    endtask

    task automatic t_irq();
        exec(`OPC_IRQ_PERMIT, 0, 0, 0);
        chk("permit", 2'b10, {irqPermitFlag, irqAcceptEnable});
        exec(10'h000, 0, 0, 0);
        chk("ignored", 0, opRecognised);
        chk("accept", 1, irqAcceptEnable);
        irqPermitClear = 1'b1;
        @(negedge sys_clk);
        irqPermitClear = 1'b0;
        chk("cleared", 0, {irqPermitFlag, irqAcceptEnable});
        $display("irq permit test done");
    endtask

    task automatic t_wdt();
        exec(10'h000, 1, 0, 0);
        chk("haltEarly", 0, watchdogHalted);
        exec(`OPC_WATCHDOG_HALT, 0, 0, 0);
        chk("armed", 2'b10, {watchdogHaltArmed, watchdogHalted});
        chk("skipCarry", 0, {skipNext, carryWrite});
        exec(10'h000, 1, 0, 0);
        chk("halted", 2'b01, {watchdogHaltArmed, watchdogHalted});
        $display("watchdog test done");
    endtask

    task automatic t_pd();
        exec(10'h000, 0, 1, 0);
        chk("unarmedPd", 0, {powerdownReq, powerdownArmed});
        exec(`OPC_POWERDOWN_ARM, 0, 0, 0);
        chk("pdArmed", 1, powerdownArmed);
        exec(10'h000, 0, 1, 0);
        chk("pdReq", 2'b10, {powerdownReq, powerdownArmed});
        @(negedge sys_clk);
        chk("pdPulse", 0, powerdownReq);
        exec(`OPC_POWERDOWN_ARM, 0, 0, 0);
        exec(10'h000, 0, 0, 1);
        chk("deepReq", 1, deepPowerdownReq);
        exec(10'h000, 0, 0, 1);
        chk("deepAgain", 0, deepPowerdownReq);
        $display("power-down test done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errCount++;
            close_out();
        end
    end

    initial begin
        repeat (8) @(negedge sys_clk);
        srst = 1'b0;
        t_port();
        t_irq();
        t_wdt();
        t_pd();
        close_out();
    end
endmodule // misc_control_opcode_decode_tb
